// file: hdl/fdc_param_pkg.sv
package fdc_param_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STEP_UNIT_NS  = 500000;
  localparam int unsigned STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_PARAM  = 12'h004;
  localparam logic [11:0] ADDR_GEOM   = 12'h008;
  localparam logic [11:0] ADDR_CFG    = 12'h00C;
  localparam logic [11:0] ADDR_PERP   = 12'h010;
  localparam logic [11:0] ADDR_DATA   = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_STATE  = 12'h01C;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CMD_OP_LSB    = 0;
  localparam int unsigned CMD_HEAD_BIT  = 4;
  localparam int unsigned CMD_ND_BIT    = 5;
  localparam int unsigned CMD_SK_BIT    = 6;
  localparam int unsigned CMD_MT_BIT    = 7;
  localparam int unsigned PAR_SEC_LSB   = 0;
  localparam int unsigned PAR_EOT_LSB   = 8;
  localparam int unsigned PAR_N_LSB     = 16;
  localparam int unsigned PAR_DTL_LSB   = 24;
  localparam int unsigned GEO_SPT_LSB   = 0;
  localparam int unsigned GEO_CYL_LSB   = 8;
  localparam int unsigned GEO_DIR_BIT   = 16;
  localparam int unsigned GEO_EC_BIT    = 17;
  localparam int unsigned CFG_SRT_LSB   = 0;
  localparam int unsigned CFG_PRE_LSB   = 8;
  localparam int unsigned CFG_POLL_BIT  = 16;
  localparam int unsigned PERP_LSB      = 0;
  localparam int unsigned PERP_WG_BIT   = 0;
  localparam int unsigned PERP_OW_BIT   = 7;
  localparam int unsigned ST0_IC_LSB    = 6;
  localparam int unsigned ST0_SEEK_BIT  = 5;
  localparam int unsigned ST0_HEAD_BIT  = 2;
  localparam int unsigned ST1_ENDCY_BIT = 7;
  localparam int unsigned ST1_OVRN_BIT  = 4;
  localparam int unsigned ST2_CMARK_BIT = 6;
  localparam int unsigned ST3_RDY_BIT   = 5;
  localparam int unsigned ST3_TRK0_BIT  = 4;
  localparam int unsigned ST3_HEAD_BIT  = 2;
  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [7:0]  RST_SECTOR   = 8'h01;
  localparam logic [7:0]  RST_EOT      = 8'h12;
  localparam logic [7:0]  RST_DTL      = 8'hFF;
  localparam logic [7:0]  RST_SPT      = 8'h12;
  localparam logic [3:0]  RST_SRT      = 4'h0;
  localparam logic [7:0]  RST_PRECOMP_START_TRACK   = 8'h00;
  localparam logic [14:0] BASE_SECTOR  = 15'h0080;
  localparam logic [7:0]  FIRST_SECTOR = 8'h01;
  localparam logic [1:0]  IC_ABNORMAL  = 2'h1;
  localparam logic [1:0]  IC_READY_CHG = 2'h3;
  typedef enum logic [2:0] {
    OP_READ     = 3'b000,
    OP_READ_DEL = 3'b001,
    OP_WRITE    = 3'b010,
    OP_FORMAT   = 3'b011,
    OP_VERIFY   = 3'b100,
    OP_SEEK     = 3'b101,
    OP_SEEK_REL = 3'b110,
    OP_SENSE    = 3'b111
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_FIND = 2'b10,
    ST_XFER = 2'b11
  } fsm_t;
endpackage

// file: hdl/floppy_command_parameter_decode.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
// How it works
// - multi-track spans both heads as one track
// - after head 0 last sector, continue head 1
// - sector length is 128 shifted by code
// - non-DMA interrupts per byte, else DMA
// - perpendicular bits change only with overwrite set
// - sense command returns present cylinder
// - polling disable stops drive ready polling
// - precompensation starts at programmable track
// - transfer starts at given sector, then advances
// - relative seek moves by count from present
// - sectors per track bounds format and counted verify
// - read with skip passes over deleted sectors
// - read-deleted with skip takes deleted only
// - step interval 0.5 to 8 ms steps
// - four status bytes kept for result phase
// - write gate option moves write gate earlier
// - excess bytes discarded on read, zeroed on write
// - enable count turns verify length into sector count
module floppy_command_parameter_decode #(
  parameter int unsigned HALF_MS_CYCLES = fdc_param_pkg::STEP_UNIT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_disk_sector,
  input  wire logic        i_disk_deleted,
  input  wire logic        i_disk_ready,
  input  wire logic [7:0]  i_disk_rdata,
  input  wire logic        i_drive_ready,
  output logic      [7:0]  o_disk_wdata,
  output logic             o_write_gate,
  output logic             o_precomp_en,
  output logic             o_step,
  output logic             o_step_dir,
  output logic             o_head,
  output logic      [7:0]  o_sector,
  output logic      [7:0]  o_cylinder,
  output logic             o_dma_req,
  output logic             o_host_int
);
  localparam int unsigned TW = $clog2(HALF_MS_CYCLES + 1);

  typedef struct packed {
    fdc_param_pkg::fsm_t fsm;
    fdc_param_pkg::op_t  op;
    logic                mt;
    logic                sk;
    logic                nd;
    logic                head;
    logic [7:0]          sector;
    logic [7:0]          eot;
    logic [2:0]          n;
    logic [7:0]          special_sector_length;
    logic [7:0]          spt;
    logic [7:0]          cyl_arg;
    logic                dir;
    logic                ec;
    logic [3:0]          step_rate_interval;
    logic [7:0]          precomp_start_track;
    logic                poll_dis;
    logic [3:0]          perp;
    logic [7:0]          cyl;
    logic [7:0]          target;
    logic                sdir;
    logic [14:0]         bcnt;
    logic [7:0]          nsec;
    logic                xfer_on;
    logic                wg;
    logic [7:0]          data;
    logic                pending;
    logic                done_int;
    logic [7:0]          st0;
    logic [7:0]          st1;
    logic [7:0]          st2;
    logic [7:0]          st3;
    logic [TW-1:0]       tick;
    logic [4:0]          step_cnt;
    logic                step;
    logic                poll_prev;
    logic [31:0]         prdata;
  } regs_t;

  regs_t q;
  regs_t next_q;

  logic        tick_pulse;
  logic [14:0] phys_len;
  logic [14:0] xfer_len;
  logic        is_wr;
  logic        is_rd;
  logic        acc;
  logic        fin;
  logic        skipsec;
  logic        last_sec;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_q     = q;
    next_q.step = 1'b0;
    fin        = 1'b0;
    skipsec    = 1'b0;
    last_sec   = 1'b0;
    tick_pulse = (q.tick == TW'(HALF_MS_CYCLES - 1));
    next_q.tick = tick_pulse ? '0 : q.tick + 1'b1;
    phys_len   = fdc_param_pkg::BASE_SECTOR << q.n;
    xfer_len   = (q.n == 3'h0) ? {7'h00, q.special_sector_length} : phys_len;
    is_wr      = (q.op == fdc_param_pkg::OP_WRITE) || (q.op == fdc_param_pkg::OP_FORMAT);
    is_rd      = (q.op == fdc_param_pkg::OP_READ) || (q.op == fdc_param_pkg::OP_READ_DEL);
    acc        = i_psel & i_penable;

    // read data is latched in the setup cycle so the access cycle needs no wait
    if (i_psel && !i_penable) begin
      if (i_paddr == fdc_param_pkg::ADDR_CMD) begin
        next_q.prdata = {24'h0000_00, q.mt, q.sk, q.nd, q.head, 1'b0, q.op};
      end else if (i_paddr == fdc_param_pkg::ADDR_PARAM) begin
        next_q.prdata = {q.special_sector_length, 5'h00, q.n, q.eot, q.sector};
      end else if (i_paddr == fdc_param_pkg::ADDR_GEOM) begin
        next_q.prdata = {14'h0000, q.ec, q.dir, q.cyl_arg, q.spt};
      end else if (i_paddr == fdc_param_pkg::ADDR_CFG) begin
        next_q.prdata = {15'h0000, q.poll_dis, q.precomp_start_track, 4'h0, q.step_rate_interval};
      end else if (i_paddr == fdc_param_pkg::ADDR_PERP) begin
        next_q.prdata = {28'h000_0000, q.perp};
      end else if (i_paddr == fdc_param_pkg::ADDR_DATA) begin
        next_q.prdata = {24'h0000_00, q.data};
      end else if (i_paddr == fdc_param_pkg::ADDR_STATUS) begin
        next_q.prdata = {q.st3, q.st2, q.st1, q.st0};
      end else if (i_paddr == fdc_param_pkg::ADDR_STATE) begin
        next_q.prdata = {8'h00, q.sector, q.cyl, 4'h0, q.fsm, q.pending, q.head};
      end else begin
        next_q.prdata = 32'h0000_0000;
      end
    end

    // ****************************************************************
    // register writes and access side effects
    // ****************************************************************
    if (acc && i_pwrite) begin
      if (i_paddr == fdc_param_pkg::ADDR_CMD) begin
        if (q.fsm == fdc_param_pkg::ST_IDLE) begin
          next_q.op       = fdc_param_pkg::op_t'(i_pwdata[fdc_param_pkg::CMD_OP_LSB +: 3]);
          next_q.mt       = i_pwdata[fdc_param_pkg::CMD_MT_BIT];
          next_q.sk       = i_pwdata[fdc_param_pkg::CMD_SK_BIT];
          next_q.nd       = i_pwdata[fdc_param_pkg::CMD_ND_BIT];
          next_q.head     = i_pwdata[fdc_param_pkg::CMD_HEAD_BIT];
          next_q.st0      = 8'h00;
          next_q.st1      = 8'h00;
          next_q.st2      = 8'h00;
          next_q.done_int = 1'b0;
          next_q.nsec     = 8'h00;
          next_q.pending  = 1'b0;
          next_q.step_cnt = {1'b0, q.step_rate_interval} + 5'h01;
          case (next_q.op)
            fdc_param_pkg::OP_SEEK: begin
              next_q.target = q.cyl_arg;
              next_q.sdir   = q.cyl_arg > q.cyl;
              next_q.fsm    = fdc_param_pkg::ST_STEP;
            end
            fdc_param_pkg::OP_SEEK_REL: begin
              next_q.sdir = q.dir;
              if (q.dir) begin
                next_q.target = q.cyl + q.cyl_arg;
              end else begin
                next_q.target = (q.cyl_arg > q.cyl) ? 8'h00 : q.cyl - q.cyl_arg;
              end
              next_q.fsm = fdc_param_pkg::ST_STEP;
            end
            fdc_param_pkg::OP_SENSE: begin
              next_q.st0 = q.st0;
              next_q.st1 = q.cyl;
            end
            default: begin
              // an early write gate must not put a stale read byte on the medium
              next_q.data = 8'h00;
              next_q.wg   = 1'b0;
              next_q.fsm  = fdc_param_pkg::ST_FIND;
            end
          endcase
        end
      end else if (i_paddr == fdc_param_pkg::ADDR_PARAM) begin
        next_q.sector = i_pwdata[fdc_param_pkg::PAR_SEC_LSB +: 8];
        next_q.eot    = i_pwdata[fdc_param_pkg::PAR_EOT_LSB +: 8];
        next_q.n      = i_pwdata[fdc_param_pkg::PAR_N_LSB +: 3];
        next_q.special_sector_length    = i_pwdata[fdc_param_pkg::PAR_DTL_LSB +: 8];
      end else if (i_paddr == fdc_param_pkg::ADDR_GEOM) begin
        next_q.spt     = i_pwdata[fdc_param_pkg::GEO_SPT_LSB +: 8];
        next_q.cyl_arg = i_pwdata[fdc_param_pkg::GEO_CYL_LSB +: 8];
        next_q.dir     = i_pwdata[fdc_param_pkg::GEO_DIR_BIT];
        next_q.ec      = i_pwdata[fdc_param_pkg::GEO_EC_BIT];
      end else if (i_paddr == fdc_param_pkg::ADDR_CFG) begin
        next_q.step_rate_interval      = i_pwdata[fdc_param_pkg::CFG_SRT_LSB +: 4];
        next_q.precomp_start_track   = i_pwdata[fdc_param_pkg::CFG_PRE_LSB +: 8];
        next_q.poll_dis = i_pwdata[fdc_param_pkg::CFG_POLL_BIT];
      end else if (i_paddr == fdc_param_pkg::ADDR_PERP) begin
        if (i_pwdata[fdc_param_pkg::PERP_OW_BIT]) begin
          next_q.perp = i_pwdata[fdc_param_pkg::PERP_LSB +: 4];
        end
      end else if (i_paddr == fdc_param_pkg::ADDR_DATA) begin
        if (is_wr && q.pending) begin
          next_q.data    = i_pwdata[7:0];
          next_q.pending = 1'b0;
        end
      end
    end else if (acc) begin
      if (i_paddr == fdc_param_pkg::ADDR_DATA && is_rd) begin
        next_q.pending = 1'b0;
      end else if (i_paddr == fdc_param_pkg::ADDR_STATUS) begin
        next_q.done_int = 1'b0;
      end
    end

    // ****************************************************************
    // command execution
    // ****************************************************************
    case (q.fsm)
      fdc_param_pkg::ST_STEP: begin
        if (q.cyl == q.target) begin
          fin = 1'b1;
          next_q.st0[fdc_param_pkg::ST0_SEEK_BIT] = 1'b1;
        end else if (tick_pulse) begin
          if (q.step_cnt == 5'h01) begin
            next_q.step     = 1'b1;
            next_q.cyl      = q.sdir ? q.cyl + 8'h01 : q.cyl - 8'h01;
            next_q.step_cnt = {1'b0, q.step_rate_interval} + 5'h01;
          end else begin
            next_q.step_cnt = q.step_cnt - 5'h01;
          end
        end
      end
      fdc_param_pkg::ST_FIND: begin
        next_q.wg = is_wr && q.perp[fdc_param_pkg::PERP_WG_BIT];
        if (i_disk_sector) begin
          skipsec = ((q.op == fdc_param_pkg::OP_READ) && q.sk && i_disk_deleted)
                 || ((q.op == fdc_param_pkg::OP_READ_DEL) && q.sk && !i_disk_deleted);
          if (is_rd && !q.sk && ((q.op == fdc_param_pkg::OP_READ) == i_disk_deleted)) begin
            next_q.st2[fdc_param_pkg::ST2_CMARK_BIT] = 1'b1;
          end
          next_q.xfer_on = (is_rd || q.op == fdc_param_pkg::OP_WRITE) && !skipsec;
          next_q.bcnt    = 15'h0000;
          next_q.data    = 8'h00;
          next_q.pending = is_wr && (q.op == fdc_param_pkg::OP_WRITE);
          next_q.wg      = is_wr;
          next_q.fsm     = fdc_param_pkg::ST_XFER;
        end
      end
      fdc_param_pkg::ST_XFER: begin
        if (i_disk_ready) begin
          next_q.bcnt = q.bcnt + 15'h0001;
          if (q.xfer_on && (q.bcnt < xfer_len)) begin
            if (is_rd) begin
              if (q.pending) begin
                next_q.st1[fdc_param_pkg::ST1_OVRN_BIT] = 1'b1;
              end
              next_q.data    = i_disk_rdata;
              next_q.pending = 1'b1;
            end else begin
              if (q.pending) begin
                next_q.st1[fdc_param_pkg::ST1_OVRN_BIT] = 1'b1;
              end
              next_q.data    = 8'h00;
              next_q.pending = (q.bcnt + 15'h0001) < xfer_len;
            end
          end else if (is_wr) begin
            next_q.data = 8'h00;
          end
          if (q.bcnt == phys_len - 15'h0001) begin
            next_q.nsec = q.nsec + 8'h01;
            if ((q.op == fdc_param_pkg::OP_FORMAT) ||
                ((q.op == fdc_param_pkg::OP_VERIFY) && q.ec)) begin
              last_sec = (q.nsec + 8'h01) == q.spt;
              next_q.sector = q.sector + 8'h01;
            end else if (q.sector == q.eot) begin
              if (q.mt && !q.head) begin
                next_q.head   = 1'b1;
                next_q.sector = fdc_param_pkg::FIRST_SECTOR;
              end else begin
                last_sec = 1'b1;
                next_q.st1[fdc_param_pkg::ST1_ENDCY_BIT] = 1'b1;
              end
            end else begin
              next_q.sector = q.sector + 8'h01;
            end
            next_q.fsm = fdc_param_pkg::ST_FIND;
            next_q.wg  = 1'b0;
            fin        = last_sec;
          end
        end
      end
      default: begin
        if (!q.poll_dis && tick_pulse) begin
          next_q.poll_prev = i_drive_ready;
          if (q.poll_prev != i_drive_ready) begin
            next_q.st0[fdc_param_pkg::ST0_IC_LSB +: 2] = fdc_param_pkg::IC_READY_CHG;
            next_q.done_int = 1'b1;
          end
        end
      end
    endcase

    // results stay readable until the next command is issued
    if (fin) begin
      next_q.fsm      = fdc_param_pkg::ST_IDLE;
      next_q.wg       = 1'b0;
      next_q.done_int = 1'b1;
      next_q.st0[fdc_param_pkg::ST0_HEAD_BIT] = q.head;
      if (next_q.st1[fdc_param_pkg::ST1_OVRN_BIT]) begin
        next_q.st0[fdc_param_pkg::ST0_IC_LSB +: 2] = fdc_param_pkg::IC_ABNORMAL;
      end
      next_q.st3 = 8'h00;
      next_q.st3[fdc_param_pkg::ST3_RDY_BIT]  = i_drive_ready;
      next_q.st3[fdc_param_pkg::ST3_TRK0_BIT] = (next_q.cyl == 8'h00);
      next_q.st3[fdc_param_pkg::ST3_HEAD_BIT] = q.head;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q          <= '0;
      q.fsm      <= fdc_param_pkg::ST_IDLE;
      q.op       <= fdc_param_pkg::OP_READ;
      q.sector   <= fdc_param_pkg::RST_SECTOR;
      q.eot      <= fdc_param_pkg::RST_EOT;
      q.special_sector_length      <= fdc_param_pkg::RST_DTL;
      q.spt      <= fdc_param_pkg::RST_SPT;
      q.step_rate_interval      <= fdc_param_pkg::RST_SRT;
      q.precomp_start_track   <= fdc_param_pkg::RST_PRECOMP_START_TRACK;
      q.step_cnt <= 5'h01;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_prdata     = q.prdata;
  assign o_pready     = 1'b1;
  assign o_pslverr    = acc && (i_paddr > fdc_param_pkg::ADDR_STATE || i_paddr[1:0] != 2'b00);
  assign o_disk_wdata = q.data;
  assign o_write_gate = q.wg;
  assign o_precomp_en = q.wg && (q.cyl >= q.precomp_start_track);
  assign o_step       = q.step;
  assign o_step_dir   = q.sdir;
  assign o_head       = q.head;
  assign o_sector     = q.sector;
  assign o_cylinder   = q.cyl;
  assign o_dma_req    = q.pending && !q.nd;
  assign o_host_int   = q.done_int || (q.pending && q.nd);
endmodule

// file: verification/disk_drive_model.sv
`timescale 1ns/10ps
module disk_drive_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_alt_deleted,
  input  wire logic       i_write_gate,
  input  wire logic [7:0] i_wdata,
  output logic            o_sector_mark,
  output logic            o_deleted,
  output logic            o_byte_strobe,
  output logic      [7:0] o_rdata,
  output logic            o_drive_ready,
  output int              o_nonzero
);
  int pos;
  // one rotation: mark, gap, then 128 bytes every 8 cycles
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos <= 0;
      o_sector_mark <= 1'b0;
      o_deleted <= 1'b0;
      o_byte_strobe <= 1'b0;
      o_rdata <= 8'h00;
      o_drive_ready <= 1'b0;
      o_nonzero <= 0;
    end else begin
      pos <= (pos == 1039) ? 0 : pos + 1;
      o_drive_ready <= 1'b1;
      o_sector_mark <= (pos == 0);
      if (pos == 0) o_deleted <= i_alt_deleted & ~o_deleted;
      o_byte_strobe <= (pos >= 16 && pos % 8 == 0);
      o_rdata <= (pos >= 16 && pos % 8 == 0) ? 8'((pos - 16) / 8) ^ 8'hA5 : ~o_rdata;
      if (o_byte_strobe && i_write_gate && i_wdata != 8'h00) o_nonzero <= o_nonzero + 1;
    end
  end
endmodule

// file: verification/fdc_param_sva.sv
`timescale 1ns/10ps
module fdc_param_sva #(
  parameter int unsigned HALF_MS_CYCLES = 4
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        i_disk_ready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_write_gate,
  input wire logic        o_precomp_en,
  input wire logic        o_step,
  input wire logic        o_head,
  input wire logic [7:0]  o_sector,
  input wire logic        o_dma_req
);
  logic [15:0] since_step;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // cycles since the last step pulse, saturating
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) since_step <= 16'hFFFF;
    else if (o_step) since_step <= 16'h0001;
    else if (since_step != 16'hFFFF) since_step <= since_step + 16'h0001;
  end
  chk_ready_const: assert property (o_pready)
    else $error("pready dropped");
  chk_err_map: assert property (i_psel && i_penable |->
    o_pslverr == (i_paddr > 12'h01C || i_paddr[1:0] != 2'b00)) else $error("pslverr wrong");
  chk_err_idle: assert property (!(i_psel && i_penable) |-> !o_pslverr)
    else $error("pslverr outside access");
  chk_rdata_hold: assert property (i_psel && i_penable |=> $stable(o_prdata))
    else $error("read data moved");
  chk_precomp_gate: assert property (o_precomp_en |-> o_write_gate)
    else $error("precomp without write gate");
  chk_step_pulse: assert property (o_step |=> !o_step)
    else $error("step pulse too long");
  chk_step_gap: assert property (o_step |-> since_step >= HALF_MS_CYCLES)
    else $error("steps too close");
  chk_mt_wrap: assert property ($rose(o_head) && !$past(i_psel && i_penable && i_pwrite)
    |-> o_sector == 8'h01) else $error("head 1 not at first sector");
  chk_dma_clear: assert property (o_dma_req && i_psel && i_penable && !i_pwrite &&
    i_paddr == fdc_param_pkg::ADDR_DATA && !i_disk_ready |=> !o_dma_req)
    else $error("dma request not cleared");
endmodule
bind floppy_command_parameter_decode fdc_param_sva #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_disk_ready(i_disk_ready), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_write_gate(o_write_gate),
  .o_precomp_en(o_precomp_en), .o_step(o_step), .o_head(o_head), .o_sector(o_sector),
  .o_dma_req(o_dma_req));

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, alt_del = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, smark, sdel, bstb, drdy, write_gate_option, prec, step, sdir;
  logic        head, dma_req, host_int;
  logic [7:0]  rdata, wdata, sector, cylinder;
  int          errors = 0, samples_checked = 0, cyc = 0, last_step = 0, step_gap = 0;
  int          steps = 0, nz;
  floppy_command_parameter_decode #(.HALF_MS_CYCLES(4)) DUT (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_disk_sector(smark), .i_disk_deleted(sdel), .i_disk_ready(bstb),
    .i_disk_rdata(rdata), .i_drive_ready(drdy), .o_disk_wdata(wdata), .o_write_gate(write_gate_option),
    .o_precomp_en(prec), .o_step(step), .o_step_dir(sdir), .o_head(head), .o_sector(sector),
    .o_cylinder(cylinder), .o_dma_req(dma_req), .o_host_int(host_int));
  disk_drive_model u_drive (
    .i_clk(clk), .i_rstn(rstn), .i_alt_deleted(alt_del), .i_write_gate(write_gate_option),
    .i_wdata(wdata), .o_sector_mark(smark), .o_deleted(sdel), .o_byte_strobe(bstb),
    .o_rdata(rdata), .o_drive_ready(drdy), .o_nonzero(nz));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (step === 1'b1) begin
      steps++;
      step_gap = cyc - last_step;
      last_step = cyc;
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic stuck(input string msg);
    errors++;
    $display("CHECK FAILED %0t timeout %s", $time, msg);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) stuck("apb");
    else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 500; i++) begin
      apb(1'b0, fdc_param_pkg::ADDR_STATE, 32'h0);
      if (rd[3:2] == 2'b00) break;
    end
    if (i == 500) stuck("idle");
  endtask
  task automatic xfer(input logic [31:0] cmd, input logic [31:0] par, input int exp_n);
    int n;
    int i;
    n = 0;
    apb(1'b1, fdc_param_pkg::ADDR_PARAM, par);
    apb(1'b1, fdc_param_pkg::ADDR_CMD, cmd);
    for (i = 0; i < 4000; i++) begin
      apb(1'b0, fdc_param_pkg::ADDR_STATE, 32'h0);
      if (rd[1]) begin
        chk({31'h0, dma_req}, {31'h0, ~cmd[5]}, "dma request");
        chk({31'h0, host_int | ~cmd[5]}, 32'h1, "byte interrupt");
        if (cmd[2:0] == 3'h2) apb(1'b1, fdc_param_pkg::ADDR_DATA, (n % 4) ^ 32'hA5);
        else begin
          apb(1'b0, fdc_param_pkg::ADDR_DATA, 32'h0);
          chk(rd & 32'hFF, (n % 4) ^ 32'hA5, "read byte");
        end
        n++;
      end else if (rd[3:2] == 2'b00) break;
    end
    if (i == 4000) stuck("transfer");
    chk(n, exp_n, "byte count");
    apb(1'b0, fdc_param_pkg::ADDR_STATUS, 32'h0);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, fdc_param_pkg::ADDR_PARAM, 32'h0);
    chk(rd, 32'hFF00_1201, "param reset");
    apb(1'b0, fdc_param_pkg::ADDR_GEOM, 32'h0);
    chk(rd, 32'h0000_0012, "geom reset");
    apb(1'b0, fdc_param_pkg::ADDR_STATE, 32'h0);
    chk(rd, 32'h0001_0000, "state reset");
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
    apb(1'b1, fdc_param_pkg::ADDR_PERP, 32'h0000_0005);
    apb(1'b0, fdc_param_pkg::ADDR_PERP, 32'h0);
    chk(rd & 32'hF, 32'h0, "perp no overwrite");
    apb(1'b1, fdc_param_pkg::ADDR_PERP, 32'h0000_0085);
    apb(1'b0, fdc_param_pkg::ADDR_PERP, 32'h0);
    chk(rd & 32'hF, 32'h5, "perp overwrite");
    apb(1'b1, fdc_param_pkg::ADDR_CFG, 32'h0001_FF01);
    apb(1'b0, fdc_param_pkg::ADDR_CFG, 32'h0);
    chk(rd & 32'h0001_FF0F, 32'h0001_FF01, "cfg");
    apb(1'b1, fdc_param_pkg::ADDR_CFG, 32'h0000_0001);
    apb(1'b1, fdc_param_pkg::ADDR_GEOM, 32'h0000_0312);
    apb(1'b1, fdc_param_pkg::ADDR_CMD, 32'h0000_0005);
    wait_idle();
    chk(rd & 32'hFF00, 32'h0300, "seek cylinder");
    chk(steps, 3, "seek steps");
    chk(step_gap, 8, "step interval");
    chk({31'h0, sdir}, 32'h1, "step direction");
    apb(1'b1, fdc_param_pkg::ADDR_GEOM, 32'h0000_0212);
    apb(1'b1, fdc_param_pkg::ADDR_CMD, 32'h0000_0006);
    wait_idle();
    chk({24'h0, cylinder}, 32'h1, "relative seek");
    apb(1'b1, fdc_param_pkg::ADDR_CMD, 32'h0000_0007);
    wait_idle();
    apb(1'b0, fdc_param_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'hFF00, 32'h0100, "sense cylinder");
    xfer(32'h0000_0080, 32'h0400_0101, 8);
    xfer(32'h0000_0020, 32'h0400_0101, 4);
    @(posedge clk);
    alt_del <= 1'b1;
    xfer(32'h0000_0040, 32'h0400_0201, 4);
    xfer(32'h0000_0041, 32'h0400_0201, 4);
    @(posedge clk);
    alt_del <= 1'b0;
    xfer(32'h0000_0002, 32'h0400_0101, 4);
    chk(nz, 4, "nonzero written");
    apb(1'b1, fdc_param_pkg::ADDR_GEOM, 32'h0002_0002);
    xfer(32'h0000_0004, 32'h0400_0101, 0);
    chk({24'h0, sector}, 32'h3, "verify sector count");
    wrap_up();
  end
endmodule
